// [rtcc_map.svh]
// Register offsets, field positions, reset values and build defaults of the
// calendar and capability block.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the APB window.
`define RTCC_OFF_CAL       8'h54
`define RTCC_OFF_TUNER     8'h60
`define RTCC_OFF_PIR0      8'h64
`define RTCC_OFF_PIR1      8'h68
`define RTCC_OFF_STATUS    8'h6c
`define RTCC_OFF_CAP       8'hf0

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define RTCC_CAL_RST       32'h0000_0000
`define RTCC_WORD_ZERO     32'h0000_0000
`define RTCC_FIELD_RST     5'h00

////////////////////////////////////////////////////////////////////////////////
// Capability word field positions.
`define RTCC_CAP_DT        0
`define RTCC_CAP_EXPWA     1
`define RTCC_CAP_EXPV_LSB  2
`define RTCC_CAP_EXPV_MSB  6
`define RTCC_CAP_NAR_LSB   8
`define RTCC_CAP_NAR_MSB   9
`define RTCC_CAP_NPIR      12
`define RTCC_CAP_PIR0WA    14
`define RTCC_CAP_PIR1WA    15
`define RTCC_CAP_PER0_LSB  16
`define RTCC_CAP_PER0_MSB  20
`define RTCC_CAP_PER1_LSB  24
`define RTCC_CAP_PER1_MSB  28

////////////////////////////////////////////////////////////////////////////////
// Field positions in the tuner, interval and status registers.
`define RTCC_FLD_LSB       0
`define RTCC_FLD_MSB       4
`define RTCC_ST_BUSY       0
`define RTCC_ST_LEAP       1

////////////////////////////////////////////////////////////////////////////////
// Calendar limits.
`define RTCC_SEC_MAX       6'h3b
`define RTCC_MIN_MAX       6'h3b
`define RTCC_HOUR_MAX      5'h17
`define RTCC_DAY_FIRST     5'h01
`define RTCC_MONTH_FIRST   4'h1
`define RTCC_MONTH_LAST    4'hc
`define RTCC_MONTH_FEB     4'h2
`define RTCC_LEAP_MASK     6'h03

////////////////////////////////////////////////////////////////////////////////
// Default build options of this instance.
`define RTCC_DEF_DT        1'b1
`define RTCC_DEF_EXPWA     1'b0
`define RTCC_DEF_EXPV      5'h00
`define RTCC_DEF_NAR       2'h1
`define RTCC_DEF_NPIR      1'b1
`define RTCC_DEF_PIR0WA    1'b0
`define RTCC_DEF_PIR1WA    1'b1
`define RTCC_DEF_PER0      5'h00
`define RTCC_DEF_PER1      5'h00

`endif

// [rtcc_pkg.sv]
// Types and shared helper functions of the calendar and capability block.
// Assumes rtcc_map.svh is on the include path.
`include "rtcc_map.svh"

package rtcc_pkg;

	// Packed calendar word, seconds in the low bits.
	typedef struct packed {
		logic [5:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rtcc_cal_t;

	// APB handshake state.
	typedef enum logic {
		APB_IDLE = 1'b0,
		APB_ACK  = 1'b1
	} rtcc_apb_t;

	// A year is a leap year when its two low bits are zero.
	function automatic logic isLeap(input logic [5:0] year);
		isLeap = ((year & `RTCC_LEAP_MASK) == 6'h00);
	endfunction

	// Merges write data into an old word under the byte strobes.
	function automatic logic [31:0] applyStrobe(input logic [31:0] oldWord,
		input logic [31:0] newWord, input logic [3:0] strb);
		logic [31:0] res;
		res = oldWord;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = newWord[i*8 +: 8];
		end
		applyStrobe = res;
	endfunction

endpackage

// [rtcc_cal_if.sv]
// Carrier between the register front end and the calendar counter.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface rtcc_cal_if;
	rtcc_pkg::rtcc_cal_t value;
	rtcc_pkg::rtcc_cal_t loadValue;
	logic                load;
	logic                tick;

	// Front end loads and ticks; the counter holds the value.
	modport ctrl (output loadValue, output load, output tick, input value);
	modport cnt  (input loadValue, input load, input tick, output value);
endinterface

// [rtcc_field_reg.sv]
// A five-bit field that is either software writable or a build constant.
// Assumes write enable and data come from logic on the same clock.
`timescale 1ns/10ps
`include "rtcc_map.svh"

module rtcc_field_reg #(
	parameter logic       WRITABLE = 1'b0,
	parameter logic [4:0] FIXED    = 5'h00
) (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// Write side.
	input  wire logic       wrEn,
	input  wire logic [4:0] wrData,
	// Value in use.
	output logic      [4:0] value
);

	logic [4:0] field_r;

	// A fixed field simply never takes the write, so the constant is always used.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			field_r <= `RTCC_FIELD_RST;
		else if (wrEn && WRITABLE)
			field_r <= wrData;
	end

	// Writable builds use the stored field; fixed builds use the constant.
	assign value = WRITABLE ? field_r : FIXED;
endmodule

// [rtcc_cal_counter.sv]
// Calendar counter: holds the packed calendar and advances it on a tick.
// Assumes the tick is a one-cycle pulse once per second on the same clock.
`timescale 1ns/10ps
`include "rtcc_map.svh"

module rtcc_cal_counter (
	// Clock and reset.
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Calendar carrier.
	rtcc_cal_if.cnt   cal
);

	rtcc_pkg::rtcc_cal_t cal_r;
	rtcc_pkg::rtcc_cal_t cal_nxt;

	// Last day of a month, February depending on the leap flag.
	function automatic logic [4:0] lastDay(input logic [3:0] month, input logic leap);
		case (month)
			`RTCC_MONTH_FEB:        lastDay = leap ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb: lastDay = 5'h1e;
			default:                lastDay = 5'h1f;
		endcase
	endfunction

	// One second forward; out-of-range fields wrap rather than run away.
	function automatic rtcc_pkg::rtcc_cal_t advance(input rtcc_pkg::rtcc_cal_t c);
		rtcc_pkg::rtcc_cal_t n;
		n = c;
		if (c.second < `RTCC_SEC_MAX)
			n.second = c.second + 6'h01;
		else
		begin
			n.second = 6'h00;
			if (c.minute < `RTCC_MIN_MAX)
				n.minute = c.minute + 6'h01;
			else
			begin
				n.minute = 6'h00;
				if (c.hour < `RTCC_HOUR_MAX)
					n.hour = c.hour + 5'h01;
				else
				begin
					n.hour = 5'h00;
					if (c.day < lastDay(c.month, rtcc_pkg::isLeap(c.year)))
						n.day = c.day + 5'h01;
					else
					begin
						n.day = `RTCC_DAY_FIRST;
						if (c.month < `RTCC_MONTH_LAST && c.month >= `RTCC_MONTH_FIRST)
							n.month = c.month + 4'h1;
						else
						begin
							n.month = `RTCC_MONTH_FIRST;
							n.year  = c.year + 6'h01;
						end
					end
				end
			end
		end
		advance = n;
	endfunction

	// A software load wins over a tick in the same cycle.
	assign cal_nxt = cal.load ? cal.loadValue : (cal.tick ? advance(cal_r) : cal_r);

	// Calendar storage.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			cal_r <= `RTCC_CAL_RST;
		else
			cal_r <= cal_nxt;
	end

	assign cal.value = cal_r;
endmodule

// [rtcc_top.sv]
// Calendar value and build capability registers of the timer, as an APB slave.
// Assumes the busy flag and the second tick come from the timer core on core_clk.
`timescale 1ns/10ps
`include "rtcc_map.svh"

module rtcc_top #(
	parameter logic       TUNER_PRESENT = `RTCC_DEF_DT,
	parameter logic       EXP_WRITABLE  = `RTCC_DEF_EXPWA,
	parameter logic [4:0] EXP_FIXED     = `RTCC_DEF_EXPV,
	parameter logic [1:0] NUM_ALARM     = `RTCC_DEF_NAR,
	parameter logic       NUM_PIR_CODE  = `RTCC_DEF_NPIR,
	parameter logic       PIR0_WRITABLE = `RTCC_DEF_PIR0WA,
	parameter logic       PIR1_WRITABLE = `RTCC_DEF_PIR1WA,
	parameter logic [4:0] PER0_FIXED    = `RTCC_DEF_PER0,
	parameter logic [4:0] PER1_FIXED    = `RTCC_DEF_PER1
) (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timer core.
	input  wire logic        timerBusy,
	input  wire logic        secondTick,
	// Values in use.
	output logic      [31:0] calendarValue,
	output logic             leapYear,
	output logic      [4:0]  tunerExponent,
	output logic      [4:0]  tapSelect0,
	output logic      [4:0]  tapSelect1
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	rtcc_pkg::rtcc_apb_t state_r;
	rtcc_pkg::rtcc_apb_t state_nxt;
	logic [31:0]         prdata_r;
	logic [31:0]         prdata_nxt;
	logic                pready_r;
	logic                pslverr_r;
	logic                pslverr_nxt;
	logic [31:0]         calOut_r;
	logic                leap_r;
	logic [4:0]          exp_r;
	logic [4:0]          tap0_r;
	logic [4:0]          tap1_r;

	wire                 accessPhase;
	wire                 reqTaken;
	wire                 commit;
	wire                 writeCommit;
	wire                 hitCal;
	wire                 hitTuner;
	wire                 hitPir0;
	wire                 hitPir1;
	wire                 hitStatus;
	wire                 hitCap;
	wire                 hitAny;
	wire [31:0]          capWord;
	wire [31:0]          statusWord;
	wire [31:0]          calRead;
	wire [31:0]          tunerRead;
	wire [31:0]          pir0Read;
	wire [31:0]          pir1Read;
	wire [31:0]          readWord;
	wire [31:0]          calMerged;
	wire [31:0]          tunerMerged;
	wire [31:0]          pir0Merged;
	wire [31:0]          pir1Merged;
	wire [4:0]           expValue;
	wire [4:0]           tap0Value;
	wire [4:0]           tap1Value;

	rtcc_cal_if calBus ();

	////////////////////////////////////////////////////////////////////////////
	// Register window, byte offsets in the low address byte.
	//   0x54 calendar word, read and write.
	//   0x60 tuner register, exponent in bits 4:0.
	//   0x64 interval register 0, tap select in bits 4:0.
	//   0x68 interval register 1, tap select in bits 4:0.
	//   0x6c status word, bit 0 busy and bit 1 leap year.
	//   0xf0 capability word, read only.
	// Any other offset answers with an error and reads zero.
	// Writes to the status and capability words are ignored.
	//
	// Calendar word layout, low bits first.
	//   Bits 5:0 hold the seconds, zero to fifty-nine.
	//   Bits 11:6 hold the minutes, zero to fifty-nine.
	//   Bits 16:12 hold the hours, zero to twenty-three.
	//   Bits 21:17 hold the day of the month, starting at one.
	//   Bits 25:22 hold the month, January being one.
	//   Bits 31:26 hold the year, leap when its two low bits are zero.
	// Values outside these ranges are stored as written and wrap on the
	// next carry into the field, so software must write legal values.
	//
	// Capability word layout, low bits first.
	//   Bit 0 shows that the tuner is present.
	//   Bit 1 shows that the tuner exponent is writable.
	//   Bits 6:2 give the fixed tuner exponent.
	//   Bits 9:8 give the number of alarm comparators.
	//   Bit 12 gives the periodic comparators, zero meaning one.
	//   Bit 14 shows that interval 0 tap select is writable.
	//   Bit 15 shows that interval 1 tap select is writable.
	//   Bits 20:16 give the fixed tapping of interval 0.
	//   Bits 28:24 give the fixed tapping of interval 1.
	// All other bits read zero.
	//
	// Bus timing seen by the master.
	//   Setup cycle: psel high, penable low.
	//   First access cycle: the request is taken and read data captured.
	//   Second access cycle: pready, prdata and pslverr stand for it.
	//   A write lands at the edge that samples pready high.
	// The slave never adds more than the one wait state, so a master may
	// start its next setup cycle straight after the answer cycle.
	//
	// Busy handling.
	//   A calendar write that lands while timerBusy is high is dropped.
	//   A calendar read taken while timerBusy is high returns zero.
	//   Neither case raises pslverr, so software must poll status first.
	//   Ticks keep advancing the calendar while the core is busy.
	//   Busy only guards the calendar; the other registers stay open.
	//
	// Fixed fields.
	//   A field built as fixed ignores writes and reads its constant.
	//   A writable field resets to zero and reads what was last written.
	//   The outputs to the timer core follow one cycle after the fields.
	//
	// Reset.
	//   Every flop clears while reset_n is low, the outputs included.
	//   Fixed field outputs show their constant one edge after release.

	////////////////////////////////////////////////////////////////////////////
	// Address decode.

	// Only the low address byte is decoded; the window is mirrored above it.
	assign hitCal    = (paddr == `RTCC_OFF_CAL);
	assign hitTuner  = (paddr == `RTCC_OFF_TUNER);
	assign hitPir0   = (paddr == `RTCC_OFF_PIR0);
	assign hitPir1   = (paddr == `RTCC_OFF_PIR1);
	assign hitStatus = (paddr == `RTCC_OFF_STATUS);
	assign hitCap    = (paddr == `RTCC_OFF_CAP);
	assign hitAny    = hitCal | hitTuner | hitPir0 | hitPir1 | hitStatus | hitCap;

	////////////////////////////////////////////////////////////////////////////
	// APB handshake.

	// Every transfer gets one wait state, so read data can come from a flop.
	assign accessPhase = psel & penable;
	assign reqTaken    = accessPhase & (state_r == rtcc_pkg::APB_IDLE);
	assign commit      = accessPhase & (state_r == rtcc_pkg::APB_ACK);
	assign writeCommit = commit & pwrite & hitAny;

	// The acknowledge state always returns to idle after one cycle.
	assign state_nxt   = reqTaken ? rtcc_pkg::APB_ACK : rtcc_pkg::APB_IDLE;

	// An unmapped address answers with an error and has no other effect.
	assign pslverr_nxt = reqTaken ? ~hitAny : 1'b0;

	// Read data is captured when the request is taken and held for the answer.
	assign prdata_nxt  = (reqTaken && !pwrite) ? readWord : `RTCC_WORD_ZERO;

	// Handshake state.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			state_r <= rtcc_pkg::APB_IDLE;
		else
			state_r <= state_nxt;
	end

	// Answer flops; pready is high for exactly the acknowledge cycle.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= `RTCC_WORD_ZERO;
		end
		else
		begin
			pready_r  <= (state_nxt == rtcc_pkg::APB_ACK);
			pslverr_r <= pslverr_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	////////////////////////////////////////////////////////////////////////////
	// Calendar write path.

	// Partial writes keep the untouched bytes of the current calendar.
	assign calMerged = rtcc_pkg::applyStrobe(calBus.value, pwdata, pstrb);

	// A write while the core is busy is dropped without an error response.
	assign calBus.load      = writeCommit & hitCal & ~timerBusy;
	assign calBus.loadValue = calMerged;
	assign calBus.tick      = secondTick;

	rtcc_cal_counter u_counter (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.cal      (calBus.cnt)
	);

	////////////////////////////////////////////////////////////////////////////
	// Tuner exponent and periodic tap fields.

	// The field sits in the low bits of each register; other bits read zero.
	assign tunerMerged = rtcc_pkg::applyStrobe(tunerRead, pwdata, pstrb);
	assign pir0Merged  = rtcc_pkg::applyStrobe(pir0Read, pwdata, pstrb);
	assign pir1Merged  = rtcc_pkg::applyStrobe(pir1Read, pwdata, pstrb);

	rtcc_field_reg #(
		.WRITABLE (EXP_WRITABLE),
		.FIXED    (EXP_FIXED)
	) u_exponent (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.wrEn     (writeCommit & hitTuner),
		.wrData   (tunerMerged[`RTCC_FLD_MSB:`RTCC_FLD_LSB]),
		.value    (expValue)
	);

	rtcc_field_reg #(
		.WRITABLE (PIR0_WRITABLE),
		.FIXED    (PER0_FIXED)
	) u_tap0 (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.wrEn     (writeCommit & hitPir0),
		.wrData   (pir0Merged[`RTCC_FLD_MSB:`RTCC_FLD_LSB]),
		.value    (tap0Value)
	);

	rtcc_field_reg #(
		.WRITABLE (PIR1_WRITABLE),
		.FIXED    (PER1_FIXED)
	) u_tap1 (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.wrEn     (writeCommit & hitPir1),
		.wrData   (pir1Merged[`RTCC_FLD_MSB:`RTCC_FLD_LSB]),
		.value    (tap1Value)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read words.

	// The stored calendar is hidden while the core is updating it.
	assign calRead = timerBusy ? `RTCC_WORD_ZERO : calBus.value;

	// Field registers read back the value in use, fixed or written.
	assign tunerRead = {27'h0000000, expValue};
	assign pir0Read  = {27'h0000000, tap0Value};
	assign pir1Read  = {27'h0000000, tap1Value};

	// Status shows the busy flag and the leap flag of the current year.
	assign statusWord = {30'h00000000, leap_r, timerBusy};

	// Capability word is tied to the build parameters; writes never reach it.
	assign capWord[`RTCC_CAP_DT]    = TUNER_PRESENT;
	assign capWord[`RTCC_CAP_EXPWA] = EXP_WRITABLE;
	assign capWord[`RTCC_CAP_EXPV_MSB:`RTCC_CAP_EXPV_LSB] = EXP_FIXED;
	assign capWord[7]               = 1'b0;
	assign capWord[`RTCC_CAP_NAR_MSB:`RTCC_CAP_NAR_LSB] = NUM_ALARM;
	assign capWord[11:10]           = 2'h0;
	assign capWord[`RTCC_CAP_NPIR]  = NUM_PIR_CODE;
	assign capWord[13]              = 1'b0;
	assign capWord[`RTCC_CAP_PIR0WA] = PIR0_WRITABLE;
	assign capWord[`RTCC_CAP_PIR1WA] = PIR1_WRITABLE;
	assign capWord[`RTCC_CAP_PER0_MSB:`RTCC_CAP_PER0_LSB] = PER0_FIXED;
	assign capWord[23:21]           = 3'h0;
	assign capWord[`RTCC_CAP_PER1_MSB:`RTCC_CAP_PER1_LSB] = PER1_FIXED;
	assign capWord[31:29]           = 3'h0;

	// Read selection; unmapped addresses read zero.
	assign readWord = hitCal    ? calRead    :
	                  hitTuner  ? tunerRead  :
	                  hitPir0   ? pir0Read   :
	                  hitPir1   ? pir1Read   :
	                  hitStatus ? statusWord :
	                  hitCap    ? capWord    : `RTCC_WORD_ZERO;

	////////////////////////////////////////////////////////////////////////////
	// Registered value outputs.

	// These lag the internal state by one cycle so every output is a flop.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			calOut_r <= `RTCC_CAL_RST;
			leap_r   <= 1'b0;
			exp_r    <= `RTCC_FIELD_RST;
			tap0_r   <= `RTCC_FIELD_RST;
			tap1_r   <= `RTCC_FIELD_RST;
		end
		else
		begin
			calOut_r <= calBus.value;
			leap_r   <= rtcc_pkg::isLeap(calBus.value.year);
			exp_r    <= expValue;
			tap0_r   <= tap0Value;
			tap1_r   <= tap1Value;
		end
	end

	assign calendarValue = calOut_r;
	assign leapYear      = leap_r;
	assign tunerExponent = exp_r;
	assign tapSelect0    = tap0_r;
	assign tapSelect1    = tap1_r;
endmodule

// [rtcc_monitor.sv]
// Checker of the calendar and capability block, watching its top ports only.
// Assumes one clock domain and that it is attached by the bind at the foot.
`timescale 1ns/10ps
`include "rtcc_map.svh"

module rtcc_monitor #(
	parameter logic       EXP_WRITABLE  = 1'b0,
	parameter logic [4:0] EXP_FIXED     = 5'h00,
	parameter logic       PIR0_WRITABLE = 1'b0,
	parameter logic [4:0] PER0_FIXED    = 5'h00
) (
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        reset_n,
	// APB slave.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// Timer core and values in use.
	input wire logic        timerBusy,
	input wire logic        secondTick,
	input wire logic [31:0] calendarValue,
	input wire logic        leapYear,
	input wire logic [4:0]  tunerExponent,
	input wire logic [4:0]  tapSelect0
);
	// A tick is judged only when no calendar write lands with it, since a load wins.
	wire       calWr    = pready && pwrite && paddr == `RTCC_OFF_CAL;
	wire       tickOnly = secondTick && !calWr;
	wire [5:0] secV     = calendarValue[5:0];

	default clocking dcb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer, busy handling and loads.
	property p_answer; psel && $rose(penable) |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("answer not one cycle after take");
	property p_busyRd; psel && penable && !pready && !pwrite && paddr == `RTCC_OFF_CAL
		&& timerBusy |=> prdata == 32'h0; endproperty
	a_busyRd: assert property (p_busyRd) else $error("busy read not zero");
	property p_busyWr; calWr && timerBusy && !secondTick |=> ##1 $stable(calendarValue);
	endproperty
	a_busyWr: assert property (p_busyWr) else $error("busy write changed calendar");
	property p_load; calWr && !timerBusy && pstrb == 4'hf |=> ##1
		calendarValue == $past(pwdata, 2); endproperty
	a_load: assert property (p_load) else $error("calendar load wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Counting and leap year.
	property p_leap; $past(reset_n) |-> leapYear == (calendarValue[27:26] == 2'b00);
	endproperty
	a_leap: assert property (p_leap) else $error("leap flag wrong");
	property p_sec; tickOnly ##1 secV < 6'h3b |=> secV == $past(secV) + 6'h01; endproperty
	a_sec: assert property (p_sec) else $error("second not advanced");
	property p_min; tickOnly ##1 calendarValue[11:0] == 12'hefb |=>
		calendarValue[11:0] == 12'h000; endproperty
	a_min: assert property (p_min) else $error("minute wrap wrong");
	property p_hour; tickOnly ##1 calendarValue[16:0] == 17'h17efb |=>
		calendarValue[16:0] == 17'h00000; endproperty
	a_hour: assert property (p_hour) else $error("hour wrap wrong");
	property p_year; tickOnly ##1 calendarValue[25:0] == 26'h33f7efb |=>
		calendarValue[25:0] == 26'h0420000
		&& calendarValue[31:26] == $past(calendarValue[31:26]) + 6'h01; endproperty
	a_year: assert property (p_year) else $error("year wrap wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Fixed fields keep their build value whatever software writes.
	property p_exp; $past(reset_n) && !EXP_WRITABLE |-> tunerExponent == EXP_FIXED;
	endproperty
	a_exp: assert property (p_exp) else $error("fixed exponent moved");
	property p_tap0; $past(reset_n) && !PIR0_WRITABLE |-> tapSelect0 == PER0_FIXED;
	endproperty
	a_tap0: assert property (p_tap0) else $error("fixed tapping moved");
endmodule

bind rtcc_top rtcc_monitor #(.EXP_WRITABLE(EXP_WRITABLE), .EXP_FIXED(EXP_FIXED),
	.PIR0_WRITABLE(PIR0_WRITABLE), .PER0_FIXED(PER0_FIXED)) rtcc_monitor_inst (
	.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
	.pready, .timerBusy, .secondTick, .calendarValue, .leapYear, .tunerExponent,
	.tapSelect0);

// [rtcc_top_tb.sv]
// Self-checking bench of the calendar and capability block, driven over APB.
// Assumes the default build parameters and a 40 MHz core clock.
`timescale 1ns/10ps
`include "rtcc_map.svh"

module rtcc_top_tb;
	logic                core_clk, reset_n, psel, penable, pwrite, timerBusy, secondTick;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, calendarValue, rnd;
	logic [3:0]          pstrb;
	logic                pready, pslverr, leapYear;
	logic [4:0]          tunerExponent, tapSelect0, tapSelect1;
	logic [32:0]         expQ[$];
	int                  errors, total_checks;
	rtcc_pkg::rtcc_cal_t cv;
	// Start date, then expected date, of each midnight rollover case.
	int                  cases[5][6] = '{'{4, 2, 28, 4, 2, 29}, '{4, 2, 29, 4, 3, 1},
		'{5, 2, 28, 5, 3, 1}, '{7, 12, 31, 8, 1, 1}, '{1, 4, 30, 1, 5, 1}};
	localparam logic [31:0] CAP = {3'h0, `RTCC_DEF_PER1, 3'h0, `RTCC_DEF_PER0,
		`RTCC_DEF_PIR1WA, `RTCC_DEF_PIR0WA, 1'b0, `RTCC_DEF_NPIR, 2'h0, `RTCC_DEF_NAR,
		1'b0, `RTCC_DEF_EXPV, `RTCC_DEF_EXPWA, `RTCC_DEF_DT};

	rtcc_top rtcc_top_inst (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .timerBusy, .secondTick,
		.calendarValue, .leapYear, .tunerExponent, .tapSelect0, .tapSelect1);

	// The clock runs at 40 MHz.
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compares one value and counts it; x or z never pass as a match.
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer, entered just after a rising edge; held until pready is seen.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		pstrb  <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	// A read notes its expected error flag and data before it goes out.
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
		expQ.push_back({err, e});
		apb(1'b0, a, 32'h0, 4'h0);
	endtask

	// One second tick, a single-cycle pulse.
	task automatic tick();
		secondTick <= 1'b1;
		@(posedge core_clk);
		secondTick <= 1'b0;
		@(posedge core_clk);
	endtask

	// Builds a date at midnight, or at its last second, 23:59:59.
	function automatic rtcc_pkg::rtcc_cal_t mk(input int y, m, d, input logic last);
		mk = '{6'(y), 4'(m), 5'(d), 5'h00, 6'h00, 6'h00};
		if (last)
			mk[16:0] = 17'h17efb;
	endfunction

	// Every read answer takes the oldest note off the queue.
	always @(posedge core_clk)
		if (pready === 1'b1 && !pwrite && expQ.size() > 0)
			cmp({pslverr, prdata}, expQ.pop_front());

	task automatic results();
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		{reset_n, psel, penable, pwrite, timerBusy, secondTick} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		errors = 0;
		total_checks = 0;
		void'($urandom(4));
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(`RTCC_OFF_CAL, `RTCC_CAL_RST, 1'b0);
		rd(`RTCC_OFF_CAP, CAP, 1'b0);
		apb(1'b1, `RTCC_OFF_CAP, $urandom, 4'hf);
		rd(`RTCC_OFF_CAP, CAP, 1'b0);
		// Random legal dates, with a write and a read under busy.
		// Seconds stay below fifty-nine so the tick never carries into the minutes.
		repeat (4)
		begin
			cv = '{6'($urandom), 4'($urandom % 12 + 1), 5'($urandom % 28 + 1),
				5'($urandom % 24), 6'($urandom % 60), 6'($urandom % 59)};
			apb(1'b1, `RTCC_OFF_CAL, cv, 4'hf);
			rd(`RTCC_OFF_CAL, cv, 1'b0);
			timerBusy <= 1'b1;
			apb(1'b1, `RTCC_OFF_CAL, ~32'(cv), 4'hf);
			rd(`RTCC_OFF_CAL, 32'h0, 1'b0);
			timerBusy <= 1'b0;
			rd(`RTCC_OFF_CAL, cv, 1'b0);
			tick();
			cv = 32'(cv) + 32'h1;
			rd(`RTCC_OFF_CAL, cv, 1'b0);
		end
		// A byte-strobed write replaces only the low byte.
		apb(1'b1, `RTCC_OFF_CAL, 32'hffff_ff25, 4'h1);
		rd(`RTCC_OFF_CAL, {cv[31:8], 8'h25}, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, `RTCC_OFF_CAL, mk(cases[i][0], cases[i][1], cases[i][2], 1'b1), 4'hf);
			tick();
			rd(`RTCC_OFF_CAL, mk(cases[i][3], cases[i][4], cases[i][5], 1'b0), 1'b0);
			cmp(calendarValue, mk(cases[i][3], cases[i][4], cases[i][5], 1'b0));
			cmp(leapYear, cases[i][3] % 4 == 0);
		end
		// Fixed fields ignore writes, the writable interval takes them.
		rnd = $urandom;
		apb(1'b1, `RTCC_OFF_TUNER, rnd, 4'hf);
		apb(1'b1, `RTCC_OFF_PIR0, rnd, 4'hf);
		apb(1'b1, `RTCC_OFF_PIR1, rnd, 4'hf);
		rd(`RTCC_OFF_TUNER, 32'(`RTCC_DEF_EXPV), 1'b0);
		rd(`RTCC_OFF_PIR0, 32'(`RTCC_DEF_PER0), 1'b0);
		rd(`RTCC_OFF_PIR1, 32'(rnd[4:0]), 1'b0);
		cmp(tunerExponent, `RTCC_DEF_EXPV);
		cmp(tapSelect0, `RTCC_DEF_PER0);
		cmp(tapSelect1, rnd[4:0]);
		rd(8'h80, 32'h0, 1'b1);
		cmp(expQ.size(), 0);
		results();
	end

	// Cuts a hung run short; the tests take well under two thousand cycles.
	initial
	begin
		#125000;
		errors++;
		results();
	end
endmodule
